// >>> hdl/ring_line_status.sv
// Ring detect output select and line condition status registers
`timescale 1ns/100ps
`include "ring_line_status_map.svh"

module ring_line_status #(
	parameter ring_line_status_pkg::oneshot_count_type ONESHOT_CYCLES =
		28'(`RING_ONESHOT_CYCLES)
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire ring_line_status_pkg::reg_byte_type reg_wdata_i,
	input wire logic ring_validation_enable_i,
	input wire logic half_wave_detect_i,
	input wire logic full_wave_detect_i,
	input wire logic validated_envelope_i,
	input wire logic ring_threshold_i,
	input wire logic receive_overload_i,
	input wire logic offhook_counter_mask_i,
	input wire logic offhook_i,
	input wire logic line_side_enabled_i,
	input wire logic loop_current_i,
	input wire logic supply_collapsed_i,
	input wire logic overcurrent_detect_i,
	output logic ring_detect_output_o,
	output logic sticky_receive_overload_flag_o,
	output logic overload_interrupt_clear_o,
	output logic overload_protect_enable_o,
	output logic ring_fullwave_select_o,
	output ring_line_status_pkg::reg_byte_type reg_rdata_o
);
	import ring_line_status_pkg::*;

	state_type state;
	state_type next_state;

	function automatic logic addr_hit(input logic [7:0] a,
		input logic [7:0] want);
		addr_hit = (a == want);
	endfunction : addr_hit

	function automatic reg_byte_type set_bit(input int pos, input logic v);
		reg_byte_type b;
		b = 8'h00;
		b[pos] = v;
		set_bit = b;
	endfunction : set_bit

	// Only the off-hook counter may hide the live flag; the billing
	// tone enable is deliberately not an input
	function automatic logic live_overload_detect(input logic overload,
		input logic counter_mask);
		logic shown;
		shown = overload & ~counter_mask;
		live_overload_detect = shown;
	endfunction : live_overload_detect

	function automatic logic dropout_detect(input logic loop_flowing,
		input logic off_hook, input logic collapsed,
		input logic side_enabled);
		logic no_loop;
		logic supply_lost;
		logic idle_enabled;
		no_loop = ~loop_flowing;
		supply_lost = off_hook & collapsed;
		idle_enabled = ~off_hook & side_enabled;
		dropout_detect = no_loop | supply_lost | idle_enabled;
	endfunction : dropout_detect

	function automatic reg_byte_type ring_select_byte(input logic fullwave,
		input logic spare);
		reg_byte_type b;
		b = 8'h00;
		b = b | set_bit(`BIT_RING_FULLWAVE, fullwave);
		b = b | set_bit(`BIT_RING_SPARE, spare);
		ring_select_byte = b;
	endfunction : ring_select_byte

	function automatic reg_byte_type line_condition_byte(input logic live,
		input logic drop, input logic over);
		reg_byte_type b;
		b = 8'h00;
		b = b | set_bit(`BIT_LIVE_RX_OVERLOAD, live);
		b = b | set_bit(`BIT_LINE_DROPOUT, drop);
		b = b | set_bit(`BIT_OVERCURRENT, over);
		line_condition_byte = b;
	endfunction : line_condition_byte

	function automatic reg_byte_type overload_control_byte(
		input logic protect, input logic sticky);
		reg_byte_type b;
		b = 8'h00;
		b = b | set_bit(`BIT_OVERLOAD_PROTECT, protect);
		b = b | set_bit(`BIT_STICKY_RX_OVERLOAD, sticky);
		overload_control_byte = b;
	endfunction : overload_control_byte

	function automatic logic ring_pin_source(input logic validate,
		input logic fullwave, input logic half_wave, input logic full_wave,
		input logic envelope, input logic oneshot);
		logic pick;
		case ({validate, fullwave})
			2'h0: begin
				pick = half_wave;
			end
			2'h1: begin
				pick = full_wave;
			end
			2'h2: begin
				pick = envelope;
			end
			2'h3: begin
				pick = oneshot;
			end
			default: begin
				pick = 1'b0;
			end
		endcase
		ring_pin_source = pick;
	endfunction : ring_pin_source

	function automatic reg_byte_type read_byte(input logic [7:0] addr,
		input reg_byte_type ring_sel, input reg_byte_type line_cond,
		input reg_byte_type ovl_ctrl);
		reg_byte_type b;
		case (addr)
			`ADDR_RING_OUTPUT_SELECT: begin
				b = ring_sel;
			end
			`ADDR_LINE_CONDITION: begin
				b = line_cond;
			end
			`ADDR_OVERLOAD_CONTROL: begin
				b = ovl_ctrl;
			end
			default: begin
				b = 8'h00;
			end
		endcase
		read_byte = b;
	endfunction : read_byte

	// Not retriggerable: a crossing during a run is ignored
	function automatic oneshot_state_type oneshot_next_state(
		input oneshot_state_type now, input logic start,
		input logic expired);
		oneshot_state_type nxt;
		nxt = now;
		case (now)
			ONESHOT_IDLE: begin
				if (start) begin
					nxt = ONESHOT_RUN;
				end
			end
			ONESHOT_RUN: begin
				if (expired) begin
					nxt = ONESHOT_IDLE;
				end
			end
			default: begin
				nxt = ONESHOT_IDLE;
			end
		endcase
		oneshot_next_state = nxt;
	endfunction : oneshot_next_state

	function automatic oneshot_count_type oneshot_next_count(
		input oneshot_state_type now, input logic start,
		input oneshot_count_type count);
		oneshot_count_type nxt;
		nxt = count;
		if (now == ONESHOT_IDLE && start) begin
			nxt = ONESHOT_CYCLES - 28'd1;
		end else if (now == ONESHOT_RUN && count != '0) begin
			nxt = count - 28'd1;
		end
		oneshot_next_count = nxt;
	endfunction : oneshot_next_count

	// Set beats clear: an overload in the cycle of the clearing write
	// must not be lost
	function automatic logic sticky_next(input logic now,
		input logic overload, input logic clear_write);
		logic nxt;
		nxt = now;
		if (clear_write) begin
			nxt = 1'b0;
		end
		if (overload) begin
			nxt = 1'b1;
		end
		sticky_next = nxt;
	endfunction : sticky_next

	logic live_overload;
	logic dropout;
	logic overcurrent;
	logic threshold_rise;
	logic wr_overload;
	logic wr_ring;
	logic sticky_clear;
	logic oneshot_expired;
	reg_byte_type ring_byte;
	reg_byte_type line_byte;
	reg_byte_type overload_byte;

	always_comb begin
		live_overload = live_overload_detect(receive_overload_i,
			offhook_counter_mask_i);
		dropout = dropout_detect(loop_current_i, offhook_i,
			supply_collapsed_i, line_side_enabled_i);
		overcurrent = overcurrent_detect_i;
		threshold_rise = ring_threshold_i & ~state.threshold_prev;
		wr_overload = reg_wr_i & addr_hit(reg_addr_i, `ADDR_OVERLOAD_CONTROL);
		wr_ring = reg_wr_i & addr_hit(reg_addr_i, `ADDR_RING_OUTPUT_SELECT);
		sticky_clear = wr_overload
			& ~reg_wdata_i[`BIT_STICKY_RX_OVERLOAD];
		oneshot_expired = (state.oneshot_count == '0);
		ring_byte = ring_select_byte(state.ring_fullwave_select,
			state.ring_spare);
		line_byte = line_condition_byte(live_overload, dropout, overcurrent);
		overload_byte = overload_control_byte(
			state.overload_protect_enable,
			state.sticky_receive_overload_flag);
	end

	always_comb begin
		next_state = state;
		next_state.threshold_prev = ring_threshold_i;

		if (wr_ring) begin
			next_state.ring_fullwave_select = reg_wdata_i[`BIT_RING_FULLWAVE];
			next_state.ring_spare = reg_wdata_i[`BIT_RING_SPARE];
		end

		// Line condition register has no write path
		if (wr_overload) begin
			next_state.overload_protect_enable =
				reg_wdata_i[`BIT_OVERLOAD_PROTECT];
		end
		next_state.overload_interrupt_clear = sticky_clear;
		next_state.sticky_receive_overload_flag = sticky_next(
			state.sticky_receive_overload_flag, receive_overload_i,
			sticky_clear);

		next_state.oneshot_state = oneshot_next_state(state.oneshot_state,
			threshold_rise, oneshot_expired);
		next_state.oneshot_count = oneshot_next_count(state.oneshot_state,
			threshold_rise, state.oneshot_count);

		next_state.ring_detect_output = ring_pin_source(
			ring_validation_enable_i, state.ring_fullwave_select,
			half_wave_detect_i, full_wave_detect_i, validated_envelope_i,
			state.oneshot_state == ONESHOT_RUN);

		if (reg_rd_i) begin
			next_state.rdata = read_byte(reg_addr_i, ring_byte, line_byte,
				overload_byte);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= '{
				ring_fullwave_select: 1'b0,
				ring_spare: 1'b0,
				overload_protect_enable: 1'b0,
				sticky_receive_overload_flag: 1'b0,
				oneshot_state: ONESHOT_IDLE,
				oneshot_count: 28'h000_0000,
				threshold_prev: 1'b0,
				ring_detect_output: 1'b0,
				rdata: `RESET_LINE_CONDITION,
				overload_interrupt_clear: 1'b0
			};
		end else begin
			state <= next_state;
		end
	end

	assign ring_detect_output_o = state.ring_detect_output;
	assign sticky_receive_overload_flag_o = state.sticky_receive_overload_flag;
	assign overload_interrupt_clear_o = state.overload_interrupt_clear;
	assign overload_protect_enable_o = state.overload_protect_enable;
	assign ring_fullwave_select_o = state.ring_fullwave_select;
	assign reg_rdata_o = state.rdata;

endmodule : ring_line_status

// >>> hdl/ring_line_status_map.svh
// Register offsets, field positions, reset values and timing for ring/line status
`ifndef RING_LINE_STATUS_MAP_SVH
`define RING_LINE_STATUS_MAP_SVH

`define ADDR_OVERLOAD_CONTROL 8'h11
`define ADDR_RING_OUTPUT_SELECT 8'h12
`define ADDR_LINE_CONDITION 8'h13

`define BIT_STICKY_RX_OVERLOAD 1
`define BIT_OVERLOAD_PROTECT 3
`define BIT_RING_FULLWAVE 1
`define BIT_RING_SPARE 2
`define BIT_LIVE_RX_OVERLOAD 2
`define BIT_LINE_DROPOUT 1
`define BIT_OVERCURRENT 0

`define RESET_RING_OUTPUT_SELECT 8'h00
`define RESET_LINE_CONDITION 8'h00

`define CLK_HZ 50_000_000
`define RING_ONESHOT_MS 5000
`define RING_ONESHOT_CYCLES (`RING_ONESHOT_MS * (`CLK_HZ / 1000))

`endif

// >>> hdl/ring_line_status_pkg.sv
// Types shared by the ring detect and line status register bank
package ring_line_status_pkg;

	typedef logic [7:0] reg_byte_type;
	typedef logic [27:0] oneshot_count_type;

	typedef enum logic [1:0] {
		ONESHOT_IDLE,
		ONESHOT_RUN
	} oneshot_state_type;

	typedef struct packed {
		logic ring_fullwave_select;
		logic ring_spare;
		logic overload_protect_enable;
		logic sticky_receive_overload_flag;
		logic overload_interrupt_clear;
		oneshot_state_type oneshot_state;
		oneshot_count_type oneshot_count;
		logic threshold_prev;
		logic ring_detect_output;
		reg_byte_type rdata;
	} state_type;

endpackage : ring_line_status_pkg

// >>> verification/line_side_model.sv
// Line-side device model: loop current and line-derived supply
`timescale 1ns/100ps
module line_side_model (
	input wire logic offhook_i,
	input wire logic line_ok_i,
	output logic loop_o,
	output logic collapsed_o
);
	assign loop_o = offhook_i && line_ok_i;
	assign collapsed_o = offhook_i && !line_ok_i;
endmodule : line_side_model

// >>> verification/ring_detect_and_line_status_tb_top.sv
// Self-checking bench for the ring select and line status registers
`timescale 1ns/100ps
module ring_detect_and_line_status_tb_top;
	import ring_line_status_pkg::*;
	logic clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, fsel, ok = 0;
	logic ring_validation_enable_i = 0, half_wave_detect_i = 0;
	logic full_wave_detect_i = 0, validated_envelope_i = 0;
	logic ring_threshold_i = 0, receive_overload_i = 0;
	logic offhook_counter_mask_i = 0, offhook_i = 0;
	logic line_side_enabled_i = 0, overcurrent_detect_i = 0;
	logic loop_current_i, supply_collapsed_i, ring_detect_output_o;
	logic sticky_receive_overload_flag_o, overload_interrupt_clear_o;
	logic overload_protect_enable_o, ring_fullwave_select_o;
	logic [7:0] reg_addr_i = 0;
	reg_byte_type reg_wdata_i = 0, reg_rdata_o;
	int n_errors = 0, total_checks = 0;
	// Bits: valid fw half full env ovl mask hook en ok oc | ring status
	logic [14:0] rows [5] = '{15'b00100_101110_1100, 15'b01100_001101_0011,
		15'b01010_110110_1010, 15'b10001_001110_1000, 15'b10110_100001_0111};
	line_side_model far_end (.offhook_i(offhook_i), .line_ok_i(ok),
		.loop_o(loop_current_i), .collapsed_o(supply_collapsed_i));
	ring_line_status #(.ONESHOT_CYCLES(28'h000_0014)) dut (.*);
	always #10 clk_i = ~clk_i;
	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		total_checks++;
		if (seen !== want) begin
			n_errors++;
			$display("BAD %0t got %h want %h", $time, seen, want);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		{reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
		@(negedge clk_i);
		reg_wr_i = 0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] want);
		@(negedge clk_i);
		{reg_addr_i, reg_rd_i} = {a, 1'b1};
		@(negedge clk_i);
		reg_rd_i = 0;
		@(negedge clk_i);
		chk(reg_rdata_o, want);
	endtask : rd
	task automatic results;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results
	initial begin
		repeat (2000) @(posedge clk_i);
		n_errors++;
		results;
	end
	initial begin
		repeat (12) @(negedge clk_i);
		rst_n_i = 1;
		rd(8'h12, 8'h00);
		for (int i = 0; i < 5; i++) begin
			wr(8'h12, {6'h00, rows[i][13], 1'b0});
			@(negedge clk_i);
			{ring_validation_enable_i, fsel, half_wave_detect_i, full_wave_detect_i,
				validated_envelope_i, receive_overload_i, offhook_counter_mask_i,
				offhook_i, line_side_enabled_i, ok, overcurrent_detect_i} = rows[i][14:4];
			@(negedge clk_i);
			chk({7'h00, ring_detect_output_o}, {7'h00, rows[i][3]});
			rd(8'h13, {5'h00, rows[i][2:0]});
		end
		receive_overload_i = 0;
		chk({7'h00, sticky_receive_overload_flag_o}, 8'h01);
		wr(8'h11, 8'h0a);
		chk({7'h00, overload_protect_enable_o}, 8'h01);
		rd(8'h11, 8'h0a);
		// Writing zero turns protection off and clears the sticky flag, pulsing the interrupt clear
		wr(8'h11, 8'h00);
		chk({7'h00, overload_interrupt_clear_o}, 8'h01);
		chk({7'h00, overload_protect_enable_o}, 8'h00);
		rd(8'h11, 8'h00);
		wr(8'h12, 8'hff);
		rd(8'h12, 8'h06);
		wr(8'h13, 8'hff);
		rd(8'h13, 8'h03);
		rd(8'h40, 8'h00);
		{ring_validation_enable_i, ring_threshold_i} = 2'b11;
		repeat (3) @(negedge clk_i);
		chk({7'h00, ring_detect_output_o}, 8'h01);
		repeat (15) @(negedge clk_i);
		chk({7'h00, ring_detect_output_o}, 8'h01);
		repeat (8) @(negedge clk_i);
		chk({7'h00, ring_detect_output_o}, 8'h00);
		// Reset after the one-shot has expired: outputs drop and registers return to reset
		wr(8'h11, 8'h08);
		rst_n_i = 0;
		@(negedge clk_i);
		chk({ring_detect_output_o, ring_fullwave_select_o,
			overload_protect_enable_o, reg_rdata_o[4:0]}, 8'h00);
		rst_n_i = 1;
		rd(8'h12, 8'h00);
		rd(8'h11, 8'h00);
		results;
	end
endmodule : ring_detect_and_line_status_tb_top

// >>> verification/ring_line_status_monitor.sv
// Assertion checker for the ring select and line status registers
`timescale 1ns/100ps
module ring_line_status_monitor (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire ring_line_status_pkg::reg_byte_type reg_wdata_i,
	input wire logic ring_validation_enable_i,
	input wire logic half_wave_detect_i,
	input wire logic full_wave_detect_i,
	input wire logic validated_envelope_i,
	input wire logic receive_overload_i,
	input wire logic ring_detect_output_o,
	input wire logic sticky_receive_overload_flag_o,
	input wire logic overload_interrupt_clear_o,
	input wire logic overload_protect_enable_o,
	input wire logic ring_fullwave_select_o,
	input wire ring_line_status_pkg::reg_byte_type reg_rdata_o
);
	import ring_line_status_pkg::*;
	wire logic f = ring_fullwave_select_o;
	wire logic s = sticky_receive_overload_flag_o;
	wire logic clr = reg_wr_i && reg_addr_i == 8'h11 && !reg_wdata_i[1];
	wire logic gap = reg_addr_i < 8'h11 || reg_addr_i > 8'h13;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence read_of(a);
		reg_rd_i && reg_addr_i == a;
	endsequence
	fw_write_a: assert property (
		reg_wr_i && reg_addr_i == 8'h12 |=> f == $past(reg_wdata_i[1]))
		else $error("full-wave bit not written");
	half_path_a: assert property (
		!ring_validation_enable_i && !f |=>
		ring_detect_output_o == $past(half_wave_detect_i))
		else $error("half-wave path wrong");
	ro_write_a: assert property (
		reg_wr_i && reg_addr_i != 8'h12 |=> $stable(f))
		else $error("full-wave bit changed");
	ring_read_a: assert property (
		read_of(8'h12) |=> reg_rdata_o[7:3] == 5'h00 &&
		!reg_rdata_o[0] && reg_rdata_o[1] == $past(f))
		else $error("select readback wrong");
	unmapped_read_a: assert property (
		reg_rd_i && gap |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	sticky_set_a: assert property (receive_overload_i |=> s)
		else $error("sticky not set");
	sticky_hold_a: assert property (s && !clr |=> s)
		else $error("sticky lost");
	sticky_clear_a: assert property (
		clr && !receive_overload_i |=> !s && overload_interrupt_clear_o)
		else $error("sticky clear failed");
	full_path_a: assert property (
		!ring_validation_enable_i && f |=>
		ring_detect_output_o == $past(full_wave_detect_i))
		else $error("full-wave path wrong");
	env_path_a: assert property (
		ring_validation_enable_i && !f |=>
		ring_detect_output_o == $past(validated_envelope_i))
		else $error("envelope path wrong");
	protect_write_a: assert property (
		reg_wr_i && reg_addr_i == 8'h11 |=>
		overload_protect_enable_o == $past(reg_wdata_i[3]))
		else $error("protect bit not written");
	clear_pulse_a: assert property (
		!clr |=> !overload_interrupt_clear_o)
		else $error("stray interrupt clear");
endmodule : ring_line_status_monitor

bind ring_line_status ring_line_status_monitor mon (.*);
